// ### flash_block_write_protect.sv
`timescale 1ns/1ps
`include "flash_protect_defs.svh"

module flash_block_write_protect (
  input  wire logic       clk,                // System clock, 50 MHz
  input  wire logic       nrst,               // Asynchronous reset, active low
  input  wire logic       sck,                // Serial clock pin
  input  wire logic       cs_n,               // Chip select pin, active low
  input  wire logic       data_line0,         // Serial input / IO0
  input  wire logic       data_line1,         // IO1
  input  wire logic       data_line2,         // IO2
  input  wire logic       data_line3,         // IO3
  input  wire logic       quad_mode,          // Four lines per cycle
  input  wire logic       dtr_mode,           // Sample both clock edges
  input  wire logic       block_protect_bit4, // Block-protect bit 4
  input  wire logic       block_protect_bit3, // Block-protect bit 3
  input  wire logic       block_protect_bit2, // Block-protect bit 2
  input  wire logic       block_protect_bit1, // Block-protect bit 1
  input  wire logic       block_protect_bit0, // Block-protect bit 0
  input  wire logic       status_write,       // Load status word, one pulse
  input  wire logic [15:0] status_wdata,      // Status word to load
  input  wire logic       soft_reset,         // Software reset, one pulse
  output logic            protect_complement, // Complement bit state
  output logic [7:0]      command,            // Last captured opcode
  output logic            op_start,           // Allowed operation, one pulse
  output logic            op_erase,           // Started op is an erase
  output logic [23:0]     op_lo,              // First byte of operation
  output logic [23:0]     op_hi,              // Last byte of operation
  output logic            op_refused,         // Refused operation, one pulse
  output logic            protection_error_flag // Sticky protection error
);

  // ------------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------------
  logic [6:0] pin_s1;
  logic [6:0] pin_s2;
  logic       sck_prev;
  wire  logic [6:0] pins = {sck, cs_n, data_line3, data_line2, data_line1, data_line0, 1'b0};

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      // Select starts high so no false select edge follows reset
      pin_s1   <= 7'h20;
      pin_s2   <= 7'h20;
      sck_prev <= 1'b0;
    end else begin
      pin_s1   <= pins;
      pin_s2   <= pin_s1;
      sck_prev <= pin_s2[6];
    end
  end

  wire logic       sck_s  = pin_s2[6];
  wire logic       cs_s   = pin_s2[5];
  wire logic [3:0] io_s   = pin_s2[4:1];
  wire logic       rise   = sck_s & ~sck_prev;
  wire logic       fall   = ~sck_s & sck_prev;
  wire logic       sample = ~cs_s & (rise | (dtr_mode & fall));

  // ------------------------------------------------------------------
  // Byte assembly
  // ------------------------------------------------------------------
  logic [7:0]  shreg;
  logic [2:0]  bitcnt;
  logic [1:0]  addr_cnt;
  logic [23:0] addr;
  logic        got_data;
  logic        cs_prev;
  flash_protect_pkg::frame_state_t state;

  wire logic [2:0] step       = quad_mode ? 3'h4 : 3'h1;
  wire logic [7:0] next_shreg = quad_mode ? {shreg[3:0], io_s} : {shreg[6:0], io_s[0]};
  wire logic [2:0] next_cnt   = bitcnt + step;
  wire logic       byte_done  = sample & (next_cnt == 3'h0);
  wire logic       cs_rise    = cs_s & ~cs_prev;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      shreg    <= 8'h00;
      bitcnt   <= 3'h0;
      addr_cnt <= 2'h0;
      addr     <= 24'h000000;
      got_data <= 1'b0;
      command  <= 8'h00;
      cs_prev  <= 1'b1;
      state    <= flash_protect_pkg::ST_IDLE;
    end else begin
      cs_prev <= cs_s;
      if (cs_s) begin
        bitcnt   <= 3'h0;
        addr_cnt <= 2'h0;
        got_data <= 1'b0;
        state    <= flash_protect_pkg::ST_IDLE;
      end else if (sample) begin
        shreg  <= next_shreg;
        bitcnt <= next_cnt;
        if (byte_done) begin
          case (state)
            flash_protect_pkg::ST_IDLE: begin
              command <= next_shreg;
              state   <= flash_protect_pkg::ST_ADDR;
            end
            flash_protect_pkg::ST_ADDR: begin
              addr     <= {addr[15:0], next_shreg};
              addr_cnt <= addr_cnt + 2'h1;
              if (addr_cnt == 2'h2) begin
                state <= flash_protect_pkg::ST_DATA;
              end
            end
            default: begin
              got_data <= 1'b1;
            end
          endcase
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // Command classification and target range
  // ------------------------------------------------------------------
  wire logic is_pp   = (command == `OP_PAGE_PROGRAM) | (command == `OP_QUAD_PAGE_PROGRAM);
  wire logic is_se   = (command == `OP_SECTOR_ERASE);
  wire logic is_b32  = (command == `OP_BLOCK_ERASE_32K);
  wire logic is_b64  = (command == `OP_BLOCK_ERASE_64K);
  wire logic is_chip = (command == `OP_CHIP_ERASE_A) | (command == `OP_CHIP_ERASE_B);
  wire logic addr_ok = (state == flash_protect_pkg::ST_DATA);

  wire logic [23:0] span = is_se  ? `SPAN_SECTOR :
                           is_b32 ? `SPAN_BLOCK_32K :
                           is_b64 ? `SPAN_BLOCK_64K : `SPAN_PAGE;
  wire logic [23:0] t_lo = is_chip ? `ADDR_BOTTOM : (addr & ~span);
  wire logic [23:0] t_hi = is_chip ? `ADDR_TOP    : (addr | span);

  wire logic [4:0] bp = {block_protect_bit4, block_protect_bit3, block_protect_bit2,
                         block_protect_bit1, block_protect_bit0};
  wire logic       hit;

  protect_range_decode u_decode (
    .bp         (bp),
    .complement (protect_complement),
    .lo_addr    (t_lo),
    .hi_addr    (t_hi),
    .hit        (hit)
  );

  // Chip erase needs an opcode in this frame, not a stale one
  wire logic valid_op = cs_rise & ((is_pp & got_data) | ((is_se | is_b32 | is_b64) & addr_ok) |
                                   (is_chip & (state != flash_protect_pkg::ST_IDLE)));
  wire logic blocked  = is_chip ? (bp != 5'h00) : hit;
  wire logic next_err = valid_op & blocked;

  // ------------------------------------------------------------------
  // Operation launch, error flag and complement bit
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      op_start              <= 1'b0;
      op_erase              <= 1'b0;
      op_lo                 <= 24'h000000;
      op_hi                 <= 24'h000000;
      op_refused            <= 1'b0;
      protection_error_flag <= 1'b0;
      protect_complement    <= `COMPLEMENT_RESET;
    end else begin
      op_start   <= valid_op & ~blocked;
      op_refused <= next_err;
      if (valid_op) begin
        op_erase <= ~is_pp;
        op_lo    <= t_lo;
        op_hi    <= t_hi;
      end
      if (next_err) begin
        protection_error_flag <= 1'b1;
      end else if (soft_reset) begin
        protection_error_flag <= 1'b0;
      end
      if (status_write) begin
        protect_complement <= status_wdata[`STATUS_COMPLEMENT_POS];
      end
    end
  end

endmodule // flash_block_write_protect

// ### flash_protect_defs.svh
`ifndef FLASH_PROTECT_DEFS_SVH
`define FLASH_PROTECT_DEFS_SVH

// Opcodes of program and erase commands
`define OP_PAGE_PROGRAM       8'h02
`define OP_QUAD_PAGE_PROGRAM  8'h32
`define OP_SECTOR_ERASE       8'h20
`define OP_BLOCK_ERASE_32K    8'h52
`define OP_BLOCK_ERASE_64K    8'hd8
`define OP_CHIP_ERASE_A       8'hc7
`define OP_CHIP_ERASE_B       8'h60

// Erase and page span masks (size minus one)
`define SPAN_SECTOR           24'h000fff
`define SPAN_BLOCK_32K        24'h007fff
`define SPAN_BLOCK_64K        24'h00ffff
`define SPAN_PAGE             24'h0000ff

// Array limits
`define ADDR_TOP              24'hffffff
`define ADDR_BOTTOM           24'h000000

// Position of the complement bit in the status word
`define STATUS_COMPLEMENT_POS 14
`define COMPLEMENT_RESET      1'b0

`endif

// ### flash_protect_pkg.sv
package flash_protect_pkg;

  typedef enum logic [1:0] {
    OP_NONE,
    OP_PROGRAM,
    OP_ERASE,
    OP_CHIP
  } op_kind_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ADDR,
    ST_DATA
  } frame_state_t;

endpackage

// ### protect_range_decode.sv
`timescale 1ns/1ps
`include "flash_protect_defs.svh"

// Protected range decode, combinational
module protect_range_decode (
  input  wire logic [4:0]  bp,         // Block-protect code
  input  wire logic        complement, // Complement bit
  input  wire logic [23:0] lo_addr,    // First byte of target
  input  wire logic [23:0] hi_addr,    // Last byte of target
  output wire logic        hit         // Target overlaps protected range
);

  // ------------------------------------------------------------------
  // Base range for complement clear
  // ------------------------------------------------------------------
  wire logic [2:0]  low3     = bp[2:0];
  wire logic        none     = (low3 == 3'h0);
  wire logic        all      = (low3 == 3'h7);
  // Codes 4, 5 and 6 all give the 32KB top or bottom range
  wire logic [2:0]  small_k  = (low3 > 3'h4) ? 3'h4 : low3;
  // Fraction ranges: size = 256KB << (low3-1)
  wire logic [23:0] frac_sz  = 24'h040000 << (low3 - 3'h1);
  // Top/bottom ranges: size = 4KB << (k-1), capped at 32KB
  wire logic [23:0] blk_sz   = 24'h001000 << (small_k - 3'h1);
  wire logic [23:0] size     = bp[4] ? blk_sz : frac_sz;
  wire logic        at_top   = ~bp[3];
  wire logic [23:0] base_lo  = at_top ? (`ADDR_TOP - size + 24'h000001) : `ADDR_BOTTOM;
  wire logic [23:0] base_hi  = at_top ? `ADDR_TOP : (size - 24'h000001);

  // Overlap with base range, full 24-bit compare
  wire logic        in_base  = all | (~none & (hi_addr >= base_lo) & (lo_addr <= base_hi));
  // Target entirely within base range
  wire logic        cov_base = all | (~none & (lo_addr >= base_lo) & (hi_addr <= base_hi));

  // Complement protects what the base leaves open
  assign hit = complement ? ~cov_base : in_base;

endmodule // protect_range_decode

// ### flash_block_write_protect_checker.sv
`timescale 1ns/1ps
// ----------------------------------------
// Port checks on the write-protect block
// ----------------------------------------
module flash_block_write_protect_checker (
  input wire logic        clk,                  // System clock
  input wire logic        nrst,                 // Reset, active low
  input wire logic        cs_n,                 // Chip select pin
  input wire logic        status_write,         // Status load pulse
  input wire logic [15:0] status_wdata,         // Status word
  input wire logic        soft_reset,           // Software reset pulse
  input wire logic        protect_complement,   // Complement bit
  input wire logic        op_start,             // Allowed op pulse
  input wire logic        op_erase,             // Op is an erase
  input wire logic [23:0] op_lo,                // First byte of op
  input wire logic [23:0] op_hi,                // Last byte of op
  input wire logic        op_refused,           // Refused op pulse
  input wire logic        protection_error_flag // Sticky error
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_err; op_refused ##[0:1] protection_error_flag; endsequence
  property p_excl; !(op_start && op_refused); endproperty
  property p_flag_set; op_refused |-> s_err; endproperty
  property p_flag_hold; protection_error_flag && !soft_reset |=> protection_error_flag; endproperty
  property p_start_one; op_start |=> !op_start; endproperty
  property p_refuse_one; op_refused |=> !op_refused; endproperty
  property p_after_cs; op_start || op_refused |-> $past(cs_n, 2) && $past(cs_n, 3); endproperty
  property p_comp_load; status_write |=> protect_complement == $past(status_wdata[14]); endproperty
  property p_comp_hold; !status_write |=> $stable(protect_complement); endproperty
  property p_range_hold; !op_start && !op_refused |-> $stable(op_lo) && $stable(op_hi); endproperty
  property p_align; op_start && op_erase |-> op_lo[11:0] == 12'h000 && op_hi[11:0] == 12'hfff; endproperty
  a_excl: assert property (p_excl) else $error("start and refuse together");
  a_flag_set: assert property (p_flag_set) else $error("flag not set");
  a_flag_hold: assert property (p_flag_hold) else $error("flag dropped");
  a_start_one: assert property (p_start_one) else $error("start too long");
  a_refuse_one: assert property (p_refuse_one) else $error("refuse too long");
  a_after_cs: assert property (p_after_cs) else $error("op before select high");
  a_comp_load: assert property (p_comp_load) else $error("complement not loaded");
  a_comp_hold: assert property (p_comp_hold) else $error("complement moved");
  a_range_hold: assert property (p_range_hold) else $error("range moved");
  a_align: assert property (p_align) else $error("erase range misaligned");
endmodule // flash_block_write_protect_checker

bind flash_block_write_protect flash_block_write_protect_checker chk_u (.clk(clk), .nrst(nrst), .cs_n(cs_n),
  .status_write(status_write), .status_wdata(status_wdata), .soft_reset(soft_reset),
  .protect_complement(protect_complement), .op_start(op_start), .op_erase(op_erase), .op_lo(op_lo),
  .op_hi(op_hi), .op_refused(op_refused), .protection_error_flag(protection_error_flag));

// ### spi_host_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Serial host driving the flash pins
// ----------------------------------------
module spi_host_model (
  input  wire logic  clk,  // Paces the pins
  input  wire logic  quad, // Four lines per sample
  input  wire logic  dtr,  // Both edges carry bits
  output logic       sck,  // Serial clock, still outside frames except during wiggle
  output logic       cs_n, // Chip select, active low
  output logic [3:0] dl    // Data lines
);
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    dl = 4'h0;
  end
  task automatic gap(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic frame(input logic [7:0] op, input logic [23:0] a, input int n);
    logic [39:0] v;
    v = {op, a, 8'($urandom)};
    gap(4);
    cs_n = 1'b0;
    for (int i = 0; i < (n + 1) * (quad ? 2 : 8); i++) begin
      dl = quad ? v[39 - 4 * i -: 4] : {4{v[39 - i]}};
      gap(4);
      if (dtr) begin
        sck = ~sck;
        gap(2);
      end else begin
        sck = 1'b1;
        gap(4);
        sck = 1'b0;
      end
    end
    gap(4);
    cs_n = 1'b1;
    dl = ~dl;
    gap(4);
  endtask
  task automatic blip();
    gap(4);
    cs_n = 1'b0;
    gap(4);
    cs_n = 1'b1;
    gap(8);
  endtask
  task automatic wiggle();
    for (int i = 0; i < 16; i++) begin
      dl = 4'($urandom);
      gap(4);
      sck = ~sck;
    end
  endtask
endmodule // spi_host_model

// ### flash_block_write_protect_tb_top.sv
`timescale 1ns/1ps
`include "flash_protect_defs.svh"
// ----------------------------------------
// Write-protect bench
// ----------------------------------------
module flash_block_write_protect_tb_top;
  logic        clk = 1'b0, nrst = 1'b0, quad_mode = 1'b0, dtr_mode = 1'b0, status_write = 1'b0;
  logic        soft_reset = 1'b0, comp = 1'b0;
  logic [4:0]  bp = 5'h00;
  logic [15:0] status_wdata = 16'h0000;
  logic [50:0] notes[$];
  logic [50:0] nt;
  logic [7:0]  opcs[5] = '{`OP_PAGE_PROGRAM, `OP_QUAD_PAGE_PROGRAM, `OP_SECTOR_ERASE, `OP_BLOCK_ERASE_32K,
                            `OP_BLOCK_ERASE_64K};
  int          miscompares = 0, comparisons = 0, cycles = 0;
  wire         sck, cs_n, protect_complement, op_start, op_erase, op_refused, protection_error_flag;
  wire [3:0]   dl;
  wire [7:0]   command;
  wire [23:0]  op_lo, op_hi;
  always #10 clk = ~clk;
  spi_host_model host_u (.clk(clk), .quad(quad_mode), .dtr(dtr_mode), .sck(sck), .cs_n(cs_n), .dl(dl));
  flash_block_write_protect dut_u (.clk(clk), .nrst(nrst), .sck(sck), .cs_n(cs_n), .data_line0(dl[0]),
    .data_line1(dl[1]), .data_line2(dl[2]), .data_line3(dl[3]), .quad_mode(quad_mode), .dtr_mode(dtr_mode),
    .block_protect_bit4(bp[4]), .block_protect_bit3(bp[3]), .block_protect_bit2(bp[2]),
    .block_protect_bit1(bp[1]), .block_protect_bit0(bp[0]), .status_write(status_write),
    .status_wdata(status_wdata), .soft_reset(soft_reset), .protect_complement(protect_complement),
    .command(command), .op_start(op_start), .op_erase(op_erase), .op_lo(op_lo), .op_hi(op_hi),
    .op_refused(op_refused), .protection_error_flag(protection_error_flag));
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("counts: %0d comparisons, %0d miscompares", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  function automatic logic prot(input logic [4:0] b, input logic c, input logic [23:0] lo, input logic [23:0] hi);
    logic [23:0] sz, blo, bhi;
    sz = b[4] ? 24'h001000 << ((b[2:0] > 3'h4 ? 3'h4 : b[2:0]) - 3'h1) : 24'h040000 << (b[2:0] - 3'h1);
    blo = b[3] ? 24'h000000 : 24'hffffff - sz + 24'h000001;
    bhi = b[3] ? sz - 24'h000001 : 24'hffffff;
    if (b[2:0] == 3'h7) {blo, bhi} = {24'h000000, 24'hffffff};
    if (b[2:0] == 3'h0) return c;
    return c ? !(lo >= blo && hi <= bhi) : (lo <= bhi && hi >= blo);
  endfunction
  task automatic setp(input logic [4:0] b, input logic c);
    @(posedge clk) #1;
    {bp, comp, status_write} = {b, c, 1'b1};
    status_wdata = (16'($urandom) & 16'hbfff) | {1'b0, c, 14'h0000};
    @(posedge clk) #1;
    status_write = 1'b0;
  endtask
  task automatic op(input logic [7:0] opc, input logic [23:0] a);
    logic [23:0] sp;
    logic        chip;
    chip = opc == `OP_CHIP_ERASE_A || opc == `OP_CHIP_ERASE_B;
    sp = opc == `OP_SECTOR_ERASE ? `SPAN_SECTOR : opc == `OP_BLOCK_ERASE_32K ? `SPAN_BLOCK_32K :
         opc == `OP_BLOCK_ERASE_64K ? `SPAN_BLOCK_64K : `SPAN_PAGE;
    if (chip) notes.push_back({1'b0, bp != 5'h00, 1'b1, 48'h0});
    else notes.push_back({1'b1, prot(bp, comp, a & ~sp, a | sp), sp != `SPAN_PAGE, a & ~sp, a | sp});
    host_u.frame(opc, a, chip ? 0 : (sp == `SPAN_PAGE ? 4 : 3));
    repeat (10) @(posedge clk);
    check(24'(command), 24'(opc));
    check(24'(notes.size()), 24'h0);
  endtask
  always @(negedge clk) begin
    if (op_start === 1'b1 || op_refused === 1'b1) begin
      if (notes.size() == 0) check(24'h1, 24'h0);
      else begin
        nt = notes.pop_front();
        check(24'(op_refused), 24'(nt[49]));
        if (nt[50] && !nt[49]) begin
          check(op_lo, nt[47:24]);
          check(op_hi, nt[23:0]);
          check(24'(op_erase), 24'(nt[48]));
        end
      end
    end
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 90000) begin
      miscompares++;
      conclude();
    end
  end
  initial begin
    void'($urandom(32'h2611958b));
    repeat (4) @(posedge clk);
    #1 nrst = 1'b1;
    repeat (4) @(posedge clk);
    check(24'(protect_complement), 24'h0);
    check(24'(protection_error_flag), 24'h0);
    $display("test reset done");
    for (int k = 0; k < 64; k++) begin
      setp(5'(k), k[5]);
      {quad_mode, dtr_mode} = 2'($urandom);
      op(`OP_SECTOR_ERASE, 24'h000000);
      op(`OP_SECTOR_ERASE, 24'hfff000);
      op(opcs[$urandom % 5], 24'($urandom));
    end
    $display("test decode done");
    for (int k = 0; k < 4; k++) begin
      setp(k[0] ? 5'h00 : 5'(1 + $urandom % 31), 1'($urandom));
      op(k[1] ? `OP_CHIP_ERASE_A : `OP_CHIP_ERASE_B, 24'h000000);
    end
    host_u.blip();
    $display("test chip erase done");
    setp(5'h07, 1'b0);
    op(`OP_SECTOR_ERASE, 24'($urandom));
    check(24'(protection_error_flag), 24'h1);
    host_u.wiggle();
    repeat (10) @(posedge clk);
    check(24'(command), 24'(`OP_SECTOR_ERASE));
    #1 soft_reset = 1'b1;
    @(posedge clk) #1 soft_reset = 1'b0;
    repeat (2) @(posedge clk);
    check(24'(protection_error_flag), 24'h0);
    $display("test error flag done");
    conclude();
  end
endmodule // flash_block_write_protect_tb_top
